//--- common/poss_pkg.sv
// Package for the proportional output safety supervisor.
// Assumes a 50 MHz system clock and AHB-Lite register access with 32-bit data.
package poss_pkg;
    // Clock rate and derived timing.
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned HOLD_OFF_MS = 250;
    localparam int unsigned HOLD_OFF_CYC = CLK_HZ / 1000 * HOLD_OFF_MS;
    // Carrier range in Hz and dither limits.
    localparam int unsigned PWM_HZ_MIN = 33;
    localparam int unsigned PWM_HZ_MAX = 4000;
    localparam int unsigned DITHER_HZ_MAX = 250;
    // Current codes are in milliamperes.
    localparam logic [15:0] TRIP_MA_MIN = 16'd5000;
    localparam logic [15:0] TRIP_MA_MAX = 16'd5250;
    localparam logic [15:0] TRIP_MA_RST = 16'd5000;
    localparam logic [15:0] DITHER_MA_MAX = 16'd500;
    localparam int unsigned DITHER_STEPS = 8;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUTY = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_DITHER = 8'h0c;
    localparam logic [7:0] OFF_TRIP = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_CURRENT = 8'h18;
    // Control register fields.
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_OCRST_BIT = 3;
    localparam int unsigned CTRL_APPRUN_BIT = 4;
    localparam int unsigned CTRL_GREEN_BIT = 5;
    localparam int unsigned CTRL_RED_BIT = 6;
    localparam int unsigned CTRL_DITHEN_BIT = 7;
    // Status register fields.
    localparam int unsigned ST_OC_BIT = 0;
    localparam int unsigned ST_OVL_BIT = 4;
    localparam int unsigned ST_MODE_BIT = 5;
    localparam int unsigned ST_SAFE_BIT = 6;
    localparam int unsigned ST_SEC_BIT = 7;
    localparam int unsigned ST_SUP_BIT = 8;
    localparam int unsigned ST_FB_BIT = 9;
    // Reset values.
    localparam logic [15:0] PERIOD_RST = 16'd50000;
    localparam logic [1:0] MODE_RST = 2'd0;
    // Output modes; code 3 is not a legal selection.
    typedef enum logic [1:0] {
        POSS_MODE_OFF = 2'd0,
        POSS_MODE_OPEN = 2'd1,
        POSS_MODE_CLOSED = 2'd2,
        POSS_MODE_BAD = 2'd3
    } poss_mode_t;
endpackage

//--- src/poss_hold_timer.sv
// Reports when a condition has stood for a full count.
// Assumes the condition comes from logic on the same clock.
`timescale 1ns/1ns
module poss_hold_timer #(
    parameter int unsigned COUNT = 12500000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cond,
    output logic done
);
    localparam int unsigned W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    initial begin
        if (COUNT < 1) begin
            $error("Hold count must be at least one cycle.");
        end
    end

    // A dropped condition restarts the count.
    always_comb begin
        cnt_next = cnt_reg;
        if (!cond) begin
            cnt_next = '0;
        end else if (cnt_reg != W'(COUNT)) begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = cond && (cnt_reg == W'(COUNT));
endmodule

//--- src/poss_supervisor.sv
// Supervisor for one proportional output with a redundant high-side switch.
// Assumes AHB-Lite from the primary, pins from the secondary and the analog front end.
// Behaviour
// - Over-current above the trip threshold (5 to 5.25 A) latches the driver off.
// - The trip latch holds until software resets it; then driving may resume.
// - Carrier period is programmable for about 763 Hz (16-bit period) to 4000 Hz, or fixed.
// - Optional dither in discrete steps up to 250 Hz and 0.5 A.
// - Sourcing passes a primary switch and a secondary switch in series.
// - The secondary may open the redundant switch at any moment.
// - An opened redundant switch stays open at least 250 ms.
// - Output follows the primary command only while the redundant switch is closed.
// - Secondary gets a digital feedback of the real redundant switch state.
// - Primary gets a measured current value for the output.
// - Overload sets bit 4; 250 ms commanded off clears it; driving also waits for the trip latch reset.
// - Invalid mode sets bit 5; cleared once a valid mode is selected.
// - Safety layer failure sets bit 6 until power cycle.
// - Secondary disable sets bit 7; clears after 250 ms off, primary off, re-enable.
// - Supply out of range sets bit 8; cleared when all off and supply good.
// - Before the application runs, green is on and red off.
// - Green-pipe yellow is primary firmware, red-pipe yellow is secondary.
// - An enabled yellow overrides the green or red sharing its pipe.
// - Software cannot drive the yellow indicators.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module poss_supervisor
#(
    parameter int unsigned HOLD_CYC = poss_pkg::HOLD_OFF_CYC,
    parameter bit FIXED_FREQ = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] current_ma,
    input wire logic sec_switch_open,
    input wire logic sec_reenable,
    input wire logic sec_switch_fb_pin,
    input wire logic safety_fail,
    input wire logic supply_ok,
    input wire logic fw_yellow_green,
    input wire logic sec_yellow_red,
    output logic proportional_output,
    output logic redundant_high_side_switch,
    output logic sec_switch_fb,
    output logic led_green,
    output logic led_red,
    output logic led_yellow_green,
    output logic led_yellow_red
);
    import poss_pkg::*;

    initial begin
        if (HOLD_CYC < 1) begin
            $error("Hold-off count must be at least one cycle.");
        end
    end

    // Two-flop synchronisers for the pins.
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] pins_in;
    assign pins_in = {sec_switch_open, sec_reenable, sec_switch_fb_pin,
                      safety_fail, supply_ok, sec_yellow_red};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 6'h02;
            sync2_reg <= 6'h02;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic s_open, s_reen, s_fb, s_fail, s_supok, s_yel_red;
    assign {s_open, s_reen, s_fb, s_fail, s_supok, s_yel_red} = sync2_reg;

    // Address phase capture; zero wait states.
    logic wr_pend_reg, wr_pend_next;
    logic rd_pend_reg, rd_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic addr_take;
    assign addr_take = hsel && hready && htrans[1];
    always_comb begin
        wr_pend_next = addr_take && hwrite;
        rd_pend_next = addr_take && !hwrite;
        addr_next = addr_take ? haddr[7:0] : addr_reg;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Software registers; yellow lamps have no field here on purpose.
    logic [7:0] ctrl_reg, ctrl_next;
    logic [15:0] duty_reg, duty_next;
    logic [15:0] period_reg, period_next;
    logic [15:0] dith_reg, dith_next;
    logic [15:0] trip_reg, trip_next;
    logic oc_rst_pulse;
    logic wr_hit;
    assign wr_hit = wr_pend_reg;
    always_comb begin
        ctrl_next = ctrl_reg;
        duty_next = duty_reg;
        period_next = period_reg;
        dith_next = dith_reg;
        trip_next = trip_reg;
        oc_rst_pulse = 1'b0;
        ctrl_next[CTRL_OCRST_BIT] = 1'b0;
        if (wr_hit) begin
            unique case (addr_reg)
                OFF_CTRL: begin
                    ctrl_next = hwdata[7:0];
                    ctrl_next[CTRL_OCRST_BIT] = 1'b0;
                    oc_rst_pulse = hwdata[CTRL_OCRST_BIT];
                end
                OFF_DUTY: duty_next = hwdata[15:0];
                OFF_PERIOD: begin
                    if (!FIXED_FREQ) begin
                        period_next = hwdata[15:0];
                    end
                end
                OFF_DITHER: dith_next = hwdata[15:0];
                OFF_TRIP: begin
                    // Clamp into the trip window.
                    if (hwdata[15:0] < TRIP_MA_MIN) begin
                        trip_next = TRIP_MA_MIN;
                    end else if (hwdata[15:0] > TRIP_MA_MAX) begin
                        trip_next = TRIP_MA_MAX;
                    end else begin
                        trip_next = hwdata[15:0];
                    end
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= 8'h00;
            duty_reg <= 16'h0000;
            period_reg <= PERIOD_RST;
            dith_reg <= 16'h0000;
            trip_reg <= TRIP_MA_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            duty_reg <= duty_next;
            period_reg <= period_next;
            dith_reg <= dith_next;
            trip_reg <= trip_next;
        end
    end

    // Clamp the period up to the 4000 Hz carrier minimum in cycles; PER_MAX is not applied.
    localparam logic [15:0] PER_MIN = 16'(CLK_HZ / PWM_HZ_MAX);
    localparam logic [20:0] PER_MAX = 21'(CLK_HZ / PWM_HZ_MIN);
    logic [15:0] period_eff;
    assign period_eff = (period_reg < PER_MIN) ? PER_MIN : period_reg;

    poss_mode_t mode;
    logic cmd_on;
    assign mode = poss_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
    assign cmd_on = ctrl_reg[CTRL_EN_BIT] && (duty_reg != 16'h0000);

    // Hold timers: switch open, command off.
    logic sw_off_held, cmd_off_held;
    logic rsw_reg, rsw_next;
    poss_hold_timer #(.COUNT(HOLD_CYC)) u_sw_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(!rsw_reg),
        .done(sw_off_held)
    );
    poss_hold_timer #(.COUNT(HOLD_CYC)) u_cmd_hold (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(!cmd_on),
        .done(cmd_off_held)
    );

    // Fault flags; a set beats a same-cycle clear.
    logic oc_reg, oc_next;
    logic [8:4] st_reg, st_next;
    logic over_i;
    assign over_i = current_ma > trip_reg;
    always_comb begin
        oc_next = oc_reg;
        st_next = st_reg;
        rsw_next = rsw_reg;
        if (oc_rst_pulse) begin
            oc_next = 1'b0;
        end
        if (over_i) begin
            oc_next = 1'b1;
        end
        if (cmd_off_held) begin
            st_next[ST_OVL_BIT] = 1'b0;
        end
        if (over_i) begin
            st_next[ST_OVL_BIT] = 1'b1;
        end
        st_next[ST_MODE_BIT] = (mode == POSS_MODE_BAD);
        if (s_fail) begin
            st_next[ST_SAFE_BIT] = 1'b1;
        end
        if (!cmd_on && s_supok) begin
            st_next[ST_SUP_BIT] = 1'b0;
        end
        if (!s_supok) begin
            st_next[ST_SUP_BIT] = 1'b1;
        end
        // Re-enable needs off time, command off and a request.
        if (rsw_reg == 1'b0 && sw_off_held && !cmd_on && s_reen && !s_open) begin
            rsw_next = 1'b1;
            st_next[ST_SEC_BIT] = 1'b0;
        end
        if (s_open) begin
            rsw_next = 1'b0;
            st_next[ST_SEC_BIT] = 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_reg <= 1'b0;
            st_reg <= 5'h00;
            rsw_reg <= 1'b1;
        end else begin
            oc_reg <= oc_next;
            st_reg <= st_next;
            rsw_reg <= rsw_next;
        end
    end

    // Dither: a stepped-rate square offset.
    localparam int unsigned DSTEP_CYC = CLK_HZ / (2 * DITHER_HZ_MAX);
    logic [31:0] dcnt_reg, dcnt_next;
    logic dphase_reg, dphase_next;
    logic [31:0] dlimit;
    logic [15:0] damp;
    assign dlimit = DSTEP_CYC * (32'(dith_reg[2:0]) + 32'd1);
    assign damp = (dith_reg[15:8] > 8'(DITHER_MA_MAX / 4)) ? 16'(DITHER_MA_MAX / 4)
                                                          : {8'h00, dith_reg[15:8]};
    always_comb begin
        dcnt_next = dcnt_reg + 32'd1;
        dphase_next = dphase_reg;
        if (dcnt_reg + 32'd1 >= dlimit) begin
            dcnt_next = 32'd0;
            dphase_next = !dphase_reg;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcnt_reg <= 32'd0;
            dphase_reg <= 1'b0;
        end else begin
            dcnt_reg <= dcnt_next;
            dphase_reg <= dphase_next;
        end
    end

    // Carrier counter; dither shifts the compare level.
    logic [15:0] pcnt_reg, pcnt_next;
    logic pwm_reg, pwm_next;
    logic [16:0] level;
    always_comb begin
        pcnt_next = (pcnt_reg + 16'd1 >= period_eff) ? 16'd0 : pcnt_reg + 16'd1;
        level = {1'b0, duty_reg};
        if (ctrl_reg[CTRL_DITHEN_BIT]) begin
            level = dphase_reg ? level + 17'(damp) : ((level > 17'(damp)) ? level - 17'(damp) : 17'd0);
        end
        pwm_next = 17'(pcnt_reg) < level;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcnt_reg <= 16'd0;
            pwm_reg <= 1'b0;
        end else begin
            pcnt_reg <= pcnt_next;
            pwm_reg <= pwm_next;
        end
    end

    // Output gating by both switches and all flags.
    logic drive_ok;
    assign drive_ok = cmd_on && !oc_reg && (st_reg == 5'h00) && (mode != POSS_MODE_OFF);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            proportional_output <= 1'b0;
        end else begin
            proportional_output <= pwm_reg && drive_ok && rsw_reg;
        end
    end
    assign redundant_high_side_switch = rsw_reg;
    assign sec_switch_fb = s_fb;

    // Lamps; yellow lines come only from firmware and secondary pins.
    logic app_run;
    assign app_run = ctrl_reg[CTRL_APPRUN_BIT];
    logic yg_sync1_reg, yg_sync2_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            yg_sync1_reg <= 1'b0;
            yg_sync2_reg <= 1'b0;
        end else begin
            yg_sync1_reg <= fw_yellow_green;
            yg_sync2_reg <= yg_sync1_reg;
        end
    end
    assign led_yellow_green = yg_sync2_reg;
    assign led_yellow_red = s_yel_red;
    assign led_green = !yg_sync2_reg && (app_run ? ctrl_reg[CTRL_GREEN_BIT] : 1'b1);
    assign led_red = !s_yel_red && app_run && ctrl_reg[CTRL_RED_BIT];

    // Read data; measured current lets the primary check its own switch.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            unique case (haddr[7:0])
                OFF_CTRL: hrdata <= {24'h000000, ctrl_reg};
                OFF_DUTY: hrdata <= {16'h0000, duty_reg};
                OFF_PERIOD: hrdata <= {16'h0000, period_eff};
                OFF_DITHER: hrdata <= {16'h0000, dith_reg};
                OFF_TRIP: hrdata <= {16'h0000, trip_reg};
                OFF_STATUS: hrdata <= {22'h000000, s_fb, st_reg, 3'h0, oc_reg};
                OFF_CURRENT: hrdata <= {16'h0000, current_ma};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks on the safety behaviour.
    logic unused_rd;
    assign unused_rd = rd_pend_reg ^ (PER_MAX == 21'd0) ^ |hsize;
    AST_TRIP_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        over_i |=> oc_reg) else $error("Over-current did not latch.");
    AST_TRIP_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        oc_reg && !oc_rst_pulse |=> oc_reg) else $error("Trip cleared without reset.");
    AST_PERIOD_MIN: assert property (@(posedge hclk) disable iff (!hresetn)
        period_eff >= PER_MIN) else $error("Carrier above range.");
    AST_OPEN_NOW: assert property (@(posedge hclk) disable iff (!hresetn)
        s_open |=> !redundant_high_side_switch) else $error("Switch not opened.");
    AST_HOLD_OPEN: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(rsw_reg) |=> !rsw_reg [*8]) else $error("Switch reopened early.");
    AST_NO_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        !rsw_reg |=> !proportional_output) else $error("Drive while switch open.");
    AST_SAFE_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg[ST_SAFE_BIT] |=> st_reg[ST_SAFE_BIT]) else $error("Bit 6 cleared.");
    AST_SEC_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        s_open |=> st_reg[ST_SEC_BIT]) else $error("Bit 7 not set.");
    AST_SUP_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        !s_supok |=> st_reg[ST_SUP_BIT]) else $error("Bit 8 not set.");
    AST_BOOT_LED: assert property (@(posedge hclk) disable iff (!hresetn)
        !app_run && !led_yellow_green |-> led_green && !led_red) else $error("Boot lamps.");
    AST_YELLOW_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        led_yellow_red |-> !led_red) else $error("Red not overridden.");
    COV_TRIP: cover property (@(posedge hclk) disable iff (!hresetn) $rose(oc_reg));
    COV_SEC_OPEN: cover property (@(posedge hclk) disable iff (!hresetn) $fell(rsw_reg));
    COV_REENABLE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(rsw_reg));
    COV_DRIVE: cover property (@(posedge hclk) disable iff (!hresetn) proportional_output);
endmodule

//--- sim/poss_sec_model.sv
// Behavioural model of the secondary safety controller beside one output.
// Assumes plain request inputs from the bench.
`timescale 1ns/1ns
module poss_sec_model #(
    parameter int unsigned FB_LAG = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic redundant_high_side_switch,
    input wire logic req_open,
    input wire logic req_reenable,
    input wire logic req_yellow,
    output logic sec_switch_open,
    output logic sec_reenable,
    output logic sec_switch_fb_pin,
    output logic sec_yellow_red
);
    logic [7:0] lag_reg;
    // Pins follow the requests one clock late.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_switch_open <= 1'b0;
            sec_reenable <= 1'b0;
            sec_yellow_red <= 1'b0;
            lag_reg <= 8'hff;
        end else begin
            sec_switch_open <= req_open;
            sec_reenable <= req_reenable;
            sec_yellow_red <= req_yellow;
            lag_reg <= {lag_reg[6:0], redundant_high_side_switch};
        end
    end
    // The sense line lags the switch.
    assign sec_switch_fb_pin = lag_reg[FB_LAG - 1];
endmodule

//--- sim/tb_poss_supervisor.sv
// Self-checking bench for the proportional output safety supervisor.
// Assumes the package and model compile first; hold-off is cut to 20.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_poss_supervisor;
    import poss_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam logic [31:0] OCRST = 32'h1 << CTRL_OCRST_BIT;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] current_ma = 16'h0;
    logic req_open = 1'b0;
    logic req_reenable = 1'b0;
    logic req_yellow = 1'b0;
    logic safety_fail = 1'b0;
    logic supply_ok = 1'b1;
    logic fw_yellow_green = 1'b0;
    logic [31:0] hrdata, rd, v;
    logic hreadyout, hresp, hi_seen;
    logic sec_switch_open, sec_reenable, sec_switch_fb_pin, sec_yellow_red;
    logic proportional_output, redundant_high_side_switch, sec_switch_fb;
    logic led_green, led_red, led_yellow_green, led_yellow_red;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Free clock; the timeout bounds every wait.
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 60000) begin
            n_errors++;
            final_report();
        end
    end
    poss_supervisor #(.HOLD_CYC(HOLD), .FIXED_FREQ(1'b0)) poss_supervisor_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .current_ma(current_ma),
        .sec_switch_open(sec_switch_open), .sec_reenable(sec_reenable),
        .sec_switch_fb_pin(sec_switch_fb_pin), .safety_fail(safety_fail), .supply_ok(supply_ok),
        .fw_yellow_green(fw_yellow_green), .sec_yellow_red(sec_yellow_red),
        .proportional_output(proportional_output),
        .redundant_high_side_switch(redundant_high_side_switch), .sec_switch_fb(sec_switch_fb),
        .led_green(led_green), .led_red(led_red), .led_yellow_green(led_yellow_green),
        .led_yellow_red(led_yellow_red));
    poss_sec_model #(.FB_LAG(2)) poss_sec_model_inst (
        .hclk(hclk), .hresetn(hresetn), .redundant_high_side_switch(redundant_high_side_switch),
        .req_open(req_open), .req_reenable(req_reenable), .req_yellow(req_yellow),
        .sec_switch_open(sec_switch_open), .sec_reenable(sec_reenable),
        .sec_switch_fb_pin(sec_switch_fb_pin), .sec_yellow_red(sec_yellow_red));
    task automatic final_report();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    // One word transfer; each phase holds until hready is seen.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        int n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdst(input int b, input logic e);
        bus(1'b0, OFF_STATUS, 32'h0, rd);
        `CHK(rd[b], e)
    endtask
    // Bounded wait for the switch (which=1) or output (which=0).
    task automatic wait_sig(input int which, input logic want, input int lim);
        while ((which ? redundant_high_side_switch : proportional_output) !== want && lim > 0) begin
            @(posedge hclk);
            lim--;
        end
    endtask
    task automatic watch_out(input int lim);
        hi_seen = 1'b0;
        repeat (lim) begin
            @(posedge hclk);
            hi_seen = hi_seen | (proportional_output === 1'b1);
        end
    endtask
    function automatic logic [31:0] cw(logic en, logic [1:0] m, logic app, logic g, logic r);
        return 32'({r, g, app, 1'b0, m, en});
    endfunction
    // Boot forces green; a lit yellow blanks its pipe partner.
    function automatic logic [3:0] lamps(logic [31:0] v);
        return {(v[2] ? v[3] : 1'b1) & ~v[0], v[2] & v[4] & ~v[1], v[0], v[1]};
    endfunction
    function automatic logic [15:0] clamp(logic [15:0] x);
        return (x < TRIP_MA_MIN) ? TRIP_MA_MIN : ((x > TRIP_MA_MAX) ? TRIP_MA_MAX : x);
    endfunction
    initial begin
        void'($urandom(32'h8896bb62));
        do_reset();
        `CHK({hresp, proportional_output, redundant_high_side_switch}, 3'h1)
        `CHK({led_green, led_red}, 2'b10)
        bus(1'b0, OFF_TRIP, 32'h0, rd);
        `CHK(rd[15:0], TRIP_MA_RST)
        // Random lamp settings against both yellows.
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            fw_yellow_green <= v[0];
            req_yellow <= v[1];
            wr(OFF_CTRL, cw(1'b0, 2'd0, v[2], v[3], v[4]) | {24'h0, v[5], 7'h0});
            repeat (5) @(posedge hclk);
            `CHK({led_green, led_red, led_yellow_green, led_yellow_red}, lamps(v))
        end
        fw_yellow_green <= 1'b0;
        req_yellow <= 1'b0;
        // Random trip, current and period readback.
        for (int i = 0; i < 6; i++) begin
            v = $urandom_range(6000, 4000);
            current_ma <= v[15:0] - 16'd1500;
            wr(OFF_TRIP, v);
            bus(1'b0, OFF_TRIP, 32'h0, rd);
            `CHK(rd[15:0], clamp(v[15:0]))
            bus(1'b0, OFF_CURRENT, 32'h0, rd);
            `CHK(rd[15:0], v[15:0] - 16'd1500)
            v = $urandom_range(65535, 12500);
            wr(OFF_PERIOD, v);
            bus(1'b0, OFF_PERIOD, 32'h0, rd);
            `CHK(rd[15:0], v[15:0])
        end
        // Half duty, then trip 1 mA over.
        current_ma <= 16'h0;
        wr(OFF_TRIP, 32'd5000);
        wr(OFF_DUTY, 32'd6250);
        wr(OFF_PERIOD, 32'd12500);
        wr(OFF_CTRL, cw(1'b1, 2'd1, 1'b1, 1'b1, 1'b0) | OCRST);
        wait_sig(0, 1'b1, 13000);
        `CHK(proportional_output, 1'b1)
        current_ma <= 16'd5001;
        repeat (4) @(posedge hclk);
        `CHK(proportional_output, 1'b0)
        current_ma <= 16'h0;
        watch_out(12600);
        `CHK(hi_seen, 1'b0)
        rdst(ST_OC_BIT, 1'b1);
        rdst(ST_OVL_BIT, 1'b1);
        wr(OFF_CTRL, cw(1'b0, 2'd1, 1'b1, 1'b1, 1'b0) | OCRST);
        repeat (HOLD + 5) @(posedge hclk);
        rdst(ST_OC_BIT, 1'b0);
        rdst(ST_OVL_BIT, 1'b0);
        wr(OFF_CTRL, cw(1'b1, 2'd1, 1'b1, 1'b1, 1'b0));
        wait_sig(0, 1'b1, 13000);
        `CHK(proportional_output, 1'b1)
        // Invalid mode and recovery.
        wr(OFF_CTRL, cw(1'b1, 2'd3, 1'b1, 1'b1, 1'b0));
        rdst(ST_MODE_BIT, 1'b1);
        wr(OFF_CTRL, cw(1'b1, 2'd2, 1'b1, 1'b1, 1'b0));
        rdst(ST_MODE_BIT, 1'b0);
        // Short open pulse with re-enable pending; hold-off still runs.
        wr(OFF_CTRL, cw(1'b0, 2'd1, 1'b1, 1'b1, 1'b0));
        req_open <= 1'b1;
        req_reenable <= 1'b1;
        repeat (3) @(posedge hclk);
        req_open <= 1'b0;
        repeat (HOLD - 6) @(posedge hclk);
        `CHK(redundant_high_side_switch, 1'b0)
        wait_sig(1, 1'b1, 40);
        `CHK(redundant_high_side_switch, 1'b1)
        rdst(ST_SEC_BIT, 1'b0);
        rdst(ST_FB_BIT, 1'b1);
        `CHK(sec_switch_fb, 1'b1)
        req_reenable <= 1'b0;
        // Open while driving; re-enable waits for command off.
        wr(OFF_CTRL, cw(1'b1, 2'd1, 1'b1, 1'b1, 1'b0));
        req_open <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK(redundant_high_side_switch, 1'b0)
        rdst(ST_SEC_BIT, 1'b1);
        rdst(ST_FB_BIT, 1'b0);
        req_open <= 1'b0;
        req_reenable <= 1'b1;
        watch_out(12600);
        `CHK(hi_seen, 1'b0)
        `CHK(redundant_high_side_switch, 1'b0)
        wr(OFF_CTRL, cw(1'b0, 2'd1, 1'b1, 1'b1, 1'b0));
        wait_sig(1, 1'b1, 40);
        `CHK(redundant_high_side_switch, 1'b1)
        req_reenable <= 1'b0;
        // Supply fault clears when off and back in range.
        wr(OFF_CTRL, cw(1'b1, 2'd1, 1'b1, 1'b1, 1'b0));
        supply_ok <= 1'b0;
        repeat (4) @(posedge hclk);
        rdst(ST_SUP_BIT, 1'b1);
        supply_ok <= 1'b1;
        repeat (4) @(posedge hclk);
        rdst(ST_SUP_BIT, 1'b1);
        wr(OFF_CTRL, cw(1'b0, 2'd1, 1'b1, 1'b1, 1'b0));
        rdst(ST_SUP_BIT, 1'b0);
        // Safety failure goes only with a reset.
        safety_fail <= 1'b1;
        repeat (4) @(posedge hclk);
        safety_fail <= 1'b0;
        wr(OFF_CTRL, cw(1'b0, 2'd0, 1'b1, 1'b1, 1'b0) | OCRST);
        rdst(ST_SAFE_BIT, 1'b1);
        do_reset();
        rdst(ST_SAFE_BIT, 1'b0);
        final_report();
    end
endmodule
